// *** sfcf_front_end.v ***
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - rank capacity-id first, status read last
// - simultaneous requests run only the top one
// - offer operations by flash density
// - sample capacity-id request every rising edge while idle
// - busy high during capacity-id command
// - capacity id valid from the edge where busy falls
// - capacity id held until the next finished id frame or reset
// - request still high restarts command
module sfcf_front_end (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        flash_miso,
   output reg         flash_cs_n,
   output reg         flash_mosi,
   output reg         flash_sclk_en,
   output reg         busy,
   output reg  [7:0]  capacity_id
);
`include "sfcf_regs.vh"
   localparam ST_IDLE = 2'd0;
   localparam ST_RUN  = 2'd1;
   localparam ST_REC  = 2'd2;

   // operation codes that the density gate looks at
   localparam OP_CAPID = 4'd0;
   localparam OP_SILID = 4'd1;
   localparam OP_FREAD = 4'd3;
   // pick result when nothing may run
   localparam NO_OP    = 5'h10;
   // density window: capid and fast read need the three largest,
   // silicon id the four smallest of the five codes
   localparam DENS_LO  = 3'h2;
   localparam DENS_HI  = 3'h3;

   reg  [1:0]                state_q;
   reg  [`SFCF_NUM_OPS-1:0]  req_q;
   reg  [3:0]                op_q;
   reg  [2:0]                dens_q;
   reg  [1:0]                rec_q;
   reg                       start_q;
   wire                      sh_cs_n;
   wire                      sh_mosi;
   wire                      sh_done;
   wire [7:0]                sh_id;
   wire                      acc;
   wire                      wr;
   wire [4:0]                sel_op;

   // density gating of each operation
   function allowed;
      input [3:0] op;
      input [2:0] dens;
      begin
         case (op)
            OP_CAPID, OP_FREAD: allowed = (dens >= DENS_LO);
            OP_SILID:           allowed = (dens <= DENS_HI);
            default:    allowed = 1'b1;
         endcase
      end
   endfunction

   // lowest index wins among allowed requests
   // capacity id ranks first
   function [4:0] pick;
      input [`SFCF_NUM_OPS-1:0] req;
      input [2:0]               dens;
      integer i;
      begin
         pick = NO_OP;
         for (i = `SFCF_NUM_OPS - 1; i >= 0; i = i - 1) begin
            if (req[i] && allowed(i[3:0], dens)) begin
               pick = {1'b0, i[3:0]};
            end
         end
      end
   endfunction

   // a transfer completes at the edge where pready is seen high
   assign acc = psel && penable && pready;
   assign wr  = acc && pwrite;

   // one arbitration result, shared by the sequencer
   assign sel_op = pick(req_q, dens_q);

   sfcf_capid_shift u_shift (
      .pclk       (pclk),
      .presetn    (presetn),
      .start      (start_q),
      .flash_miso (flash_miso),
      .flash_cs_n (sh_cs_n),
      .flash_mosi (sh_mosi),
      .done       (sh_done),
      .id_byte    (sh_id)
   );

   // apb slave, one wait state: pready rises at the end of the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         dens_q  <= `SFCF_DENS_RST;
      end else begin
         pready  <= psel && !pready && penable;
         pslverr <= 1'b0;
         if (psel && penable && !pready) begin
            pslverr <= (paddr > `SFCF_CFG_OFF) || (paddr[1:0] != 2'b00);
            // read word chosen in the first access cycle
            case (paddr)
               `SFCF_CTRL_OFF:   prdata <= {23'h0, req_q};
               `SFCF_STATUS_OFF: prdata <= {24'h0, op_q, 3'h0, busy};
               `SFCF_CAPID_OFF:  prdata <= {24'h0, capacity_id};
               `SFCF_CFG_OFF:    prdata <= {29'h0, dens_q};
               default:          prdata <= 32'h00000000;
            endcase
         end
         if (wr && paddr == `SFCF_CFG_OFF && pwdata[2:0] <= `SFCF_DENS_MAX) begin
            dens_q <= pwdata[2:0];
         end
      end
   end

   // registered pin drive, so every flash pin leaves a flip-flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_cs_n    <= 1'b1;
         flash_mosi    <= 1'b0;
         flash_sclk_en <= 1'b0;
      end else begin
         flash_cs_n    <= sh_cs_n;
         flash_mosi    <= sh_mosi;
         flash_sclk_en <= !sh_cs_n;
      end
   end

   // request levels, rewritten whole by a control write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= {`SFCF_NUM_OPS{1'b0}};
      end else begin
         if (wr && paddr == `SFCF_CTRL_OFF) begin
            req_q <= pwdata[`SFCF_NUM_OPS-1:0];
         end
      end
   end

   // captured capacity id, changed only by a finished id frame
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capacity_id <= 8'h00;
      end else begin
         if (state_q == ST_RUN && sh_done) begin
            capacity_id <= sh_id;
         end
      end
   end

   // sequencing: arbitration, busy and recovery
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         op_q    <= 4'h0;
         rec_q   <= 2'd0;
         start_q <= 1'b0;
         busy    <= 1'b0;
      end else begin
         start_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (sel_op != NO_OP) begin
                  op_q    <= sel_op[3:0];
                  busy    <= 1'b1;
                  start_q <= (sel_op == {1'b0, OP_CAPID});
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (op_q != OP_CAPID || sh_done) begin
                  busy    <= 1'b0;
                  rec_q   <= 2'd0;
                  state_q <= ST_REC;
               end
            end
            ST_REC: begin
               rec_q <= rec_q + 2'd1;
               if (rec_q == `SFCF_RECOVER_CYC - 1) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule // sfcf_front_end
`default_nettype wire

// *** sfcf_regs.vh ***
`ifndef SFCF_REGS_VH
`define SFCF_REGS_VH
// apb register byte offsets
`define SFCF_CTRL_OFF     12'h000
`define SFCF_STATUS_OFF   12'h004
`define SFCF_CAPID_OFF    12'h008
`define SFCF_CFG_OFF      12'h00c
// control register: one request bit per operation, in ranking order
`define SFCF_OP_CAPID     0
`define SFCF_OP_SILID     1
`define SFCF_OP_READ      2
`define SFCF_OP_FREAD     3
`define SFCF_OP_WRITE     4
`define SFCF_OP_SERASE    5
`define SFCF_OP_BERASE    6
`define SFCF_OP_PROTECT   7
`define SFCF_OP_STATUS    8
`define SFCF_NUM_OPS      9
// status register fields
`define SFCF_ST_BUSY      0
`define SFCF_ST_OP_LSB    4
// density codes 0..4, smallest to largest
`define SFCF_DENS_RST     3'h2
`define SFCF_DENS_MAX     3'h4
// serial opcode for the capacity id read
`define SFCF_CMD_CAPID    8'h9f
// recovery cycles after busy falls
`define SFCF_RECOVER_CYC  2
`endif

// *** sfcf_capid_shift.v ***
`timescale 1ns/10ps
`default_nettype none
// shifts the capacity-id command out and captures the returned byte
module sfcf_capid_shift (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       start,
   input  wire       flash_miso,
   output reg        flash_cs_n,
   output reg        flash_mosi,
   output reg        done,
   output reg  [7:0] id_byte
);
`include "sfcf_regs.vh"
   localparam [7:0] CMD = `SFCF_CMD_CAPID;
   reg [4:0] bit_cnt_q;
   reg [7:0] cmd_sr_q;
   reg       active_q;
   reg [7:0] rx_sr_q;

   // 8 command bits then 8 response bits, one per clock
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_q  <= 5'h00;
         cmd_sr_q   <= 8'h00;
         active_q   <= 1'b0;
         rx_sr_q    <= 8'h00;
         flash_cs_n <= 1'b1;
         flash_mosi <= 1'b0;
         done       <= 1'b0;
         id_byte    <= 8'h00;
      end else begin
         done <= 1'b0;
         if (start && !active_q) begin
            active_q   <= 1'b1;
            flash_cs_n <= 1'b0;
            bit_cnt_q  <= 5'h00;
            flash_mosi <= CMD[7];
            cmd_sr_q   <= CMD;
         end else if (active_q) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q < 5'h07) begin
               flash_mosi <= cmd_sr_q[6];
               cmd_sr_q   <= {cmd_sr_q[6:0], 1'b0};
            end else begin
               flash_mosi <= 1'b0;
            end
            // the pins leave a register in the front end, so the answer
            // arrives one cycle later than the count alone suggests
            if (bit_cnt_q >= 5'h09) begin
               rx_sr_q <= {rx_sr_q[6:0], flash_miso};
            end
            if (bit_cnt_q == 5'h10) begin
               // id is valid from the same edge as done
               id_byte    <= {rx_sr_q[6:0], flash_miso};
               active_q   <= 1'b0;
               flash_cs_n <= 1'b1;
               done       <= 1'b1;
            end
         end
      end
   end
endmodule // sfcf_capid_shift
`default_nettype wire

// *** sfcf_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module sfcf_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        flash_cs_n,
   input wire logic        flash_sclk_en,
   input wire logic        busy,
   input wire logic [7:0]  capacity_id
);
   logic [4:0] low_q;
   // counts serial cycles of the current frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) low_q <= 5'h00;
      else low_q <= flash_cs_n ? 5'h00 : low_q + 5'h01;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_recover; !busy ##1 !busy; endsequence
   property p_wait; s_setup |-> ##2 pready; endproperty
   property p_once; pready |=> !pready; endproperty
   property p_err; pready && (paddr[1:0] != 2'h0 || paddr > 12'h00c) |-> pslverr; endproperty
   property p_idle; !busy |-> flash_cs_n; endproperty
   // 8 opcode bits, 8 answer bits and one cycle of pin register lag
   property p_len; $rose(flash_cs_n) |-> low_q == 5'h11; endproperty
   property p_sclk; flash_sclk_en == !flash_cs_n; endproperty
   property p_hold; !$stable(capacity_id) |-> $fell(busy); endproperty
   property p_recover; $fell(busy) |=> s_recover; endproperty
   a_wait: assert property (p_wait) else $error("pready late");
   a_once: assert property (p_once) else $error("pready too long");
   a_err: assert property (p_err) else $error("bad address accepted");
   a_idle: assert property (p_idle) else $error("frame outside busy");
   a_len: assert property (p_len) else $error("frame length wrong");
   a_sclk: assert property (p_sclk) else $error("clock enable off frame");
   a_hold: assert property (p_hold) else $error("id changed mid run");
   a_recover: assert property (p_recover) else $error("restart too soon");
endmodule // sfcf_assertions
bind sfcf_front_end sfcf_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .flash_cs_n(flash_cs_n), .flash_sclk_en(flash_sclk_en), .busy(busy),
   .capacity_id(capacity_id));
`default_nettype wire

// *** sfcf_flash_model.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sfcf_regs.vh"
module sfcf_flash_model #(parameter logic [7:0] CAP_ID = 8'h5a) ( // arbitrary id value
   input wire logic  pclk,
   input wire logic  presetn,
   input wire logic  flash_cs_n,
   input wire logic  flash_sclk_en,
   input wire logic  flash_mosi,
   output var logic  flash_miso
);
   logic [4:0] bit_q;
   logic [7:0] cmd_q;
   logic       hit;
   assign hit = (bit_q == 5'h07) ? {cmd_q[6:0], flash_mosi} == `SFCF_CMD_CAPID
                                 : cmd_q == `SFCF_CMD_CAPID;
   // takes the opcode, answers the id msb first, toggles when idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_q <= 5'h00;
         cmd_q <= 8'h00;
         flash_miso <= 1'b0;
      end else if (flash_cs_n || !flash_sclk_en) begin
         bit_q <= 5'h00;
         flash_miso <= ~flash_miso;
      end else begin
         bit_q <= bit_q + 5'h01;
         if (bit_q < 5'h08) cmd_q <= {cmd_q[6:0], flash_mosi};
         flash_miso <= (bit_q >= 5'h07 && bit_q <= 5'h0e && hit) ?
                       CAP_ID[3'h6 - bit_q[2:0]] : ~flash_miso;
      end
   end
endmodule // sfcf_flash_model
`default_nettype wire

// *** test_serial_flash_command_front_end.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sfcf_regs.vh"
module test_serial_flash_command_front_end;
   localparam logic [7:0] ID = 8'h5a; // arbitrary id value
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, miso, cs_n, mosi, sclk_en, busy;
   logic [7:0]  cap;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [15:0] lfsr = 16'h3adf;
   logic [2:0]  d;
   int          fails = 0, tests_run = 0, rises = 0, r0, b, x;
   // free running clock
   // 50 ns period, inside both read limits
   always #25 pclk = ~pclk;
   always @(posedge busy) rises++;
   sfcf_front_end u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_miso(miso), .flash_cs_n(cs_n), .flash_mosi(mosi),
      .flash_sclk_en(sclk_en), .busy(busy), .capacity_id(cap));
   sfcf_flash_model #(.CAP_ID(ID)) u_flash (.pclk(pclk), .presetn(presetn),
      .flash_cs_n(cs_n), .flash_sclk_en(sclk_en), .flash_mosi(mosi), .flash_miso(miso));
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic conclude;
      if (fails == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic err);
      exp_q.push_back({err, v});
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wait_idle;
      repeat (2) @(posedge pclk);
      do @(posedge pclk); while (busy !== 1'b0);
      tests_run++;
      if (cap !== ID) begin
         fails++;
         $display("unexpected at %0t: %h vs %h", $time, cap, ID);
      end
      repeat (3) @(posedge pclk);
   endtask
   // compares each read answer with the oldest note
   always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      tests_run++;
      if (e[32] ? pslverr !== 1'b1 : {pslverr, prdata} !== e) begin
         fails++;
         $display("unexpected at %0t: %h vs %h", $time, {pslverr, prdata}, e);
      end
   end
   initial begin
      #(50 * 20000);
      fails++;
      conclude;
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(`SFCF_CAPID_OFF, 32'h0, 1'b0);
      rd(`SFCF_CFG_OFF, 32'h2, 1'b0);
      rd(12'h010, 32'h0, 1'b1);
      rd(12'h002, 32'h0, 1'b1);
      apb(1'b1, `SFCF_CTRL_OFF, 32'h1ff);
      rd(`SFCF_STATUS_OFF, 32'h1, 1'b0);
      apb(1'b1, `SFCF_CTRL_OFF, 32'h0);
      wait_idle;
      rd(`SFCF_CAPID_OFF, {24'h0, ID}, 1'b0);
      tests_run++;
      if (rises !== 1) begin fails++; $display("unexpected at %0t: %h vs %h", $time, rises, 1); end
      r0 = rises;
      apb(1'b1, `SFCF_CTRL_OFF, 32'h1);
      wait_idle;
      apb(1'b1, `SFCF_CTRL_OFF, 32'h0);
      wait_idle;
      tests_run++;
      if (rises - r0 !== 2) begin fails++; $display("unexpected at %0t: %h vs %h", $time, rises - r0, 2); end
      for (int i = 0; i < 6; i++) begin
         lfsr = nxt(lfsr);
         d = 3'(lfsr % 5);
         b = lfsr[8] ? 1 : 2;
         apb(1'b1, `SFCF_CFG_OFF, {29'h0, d});
         r0 = rises;
         apb(1'b1, `SFCF_CTRL_OFF, b);
         apb(1'b1, `SFCF_CTRL_OFF, 32'h0);
         wait_idle;
         tests_run++;
         x = (b == 1) ? (d >= 2) : (d <= 3);
         if (rises - r0 !== x) begin
            fails++;
            $display("unexpected at %0t: %h vs %h", $time, rises - r0, x);
         end
      end
      rd(`SFCF_CAPID_OFF, {24'h0, ID}, 1'b0);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(`SFCF_CAPID_OFF, 32'h0, 1'b0);
      conclude;
   end
endmodule // test_serial_flash_command_front_end
`default_nettype wire
